// ===== design/hit_trap_unit.sv
// interrupt pending, priority pick, trap cause and handler fetch address of one hart
// Summary of operation
// RL1 - pending bits 3, 7, 11 show software, timer, external; others reserved.
// RL2 - pending bits 16 to 31 show local interrupts 0 to 15.
// RL3 - interrupt trap sets cause top bit and interrupt number below.
// RL4 - timer interrupt leaves cause as flag plus code 7.
// RL5 - exception clears cause top bit and records exception code.
// RL6 - cause bits 62:0 hold code, bit 63 the interrupt flag.
// RL7 - exception codes 0 to 8 and 11 defined; others reserved.
// RL8 - vector mode field bits 1:0: 0 direct, 1 vectored, others reserved.
// RL9 - vector base in bits 63:2, low two address bits zero.
// RL10 - direct mode sends every trap to the vector base.
// RL11 - vectored mode sends interrupts to base plus four times code.
// RL12 - global interrupts use code 11, so base plus 0x2C.
// RL13 - software gives a 128-byte aligned base in vectored mode.
// RL14 - an enabled local interrupt beats a simultaneous global one.
// RL15 - among local interrupts the highest number wins.
// RL16 - order: local 15..0, external, software, timer.
// RL17 - signal to handler fetch takes 4 core cycles best case.
// RL18 - global interrupts add 3 controller clock cycles.
// RL19 - a running division is never cancelled by a trap.
// RL20 - reading an unfinished division result stalls the pipeline.
// RL21 - trap entry saves enable, clears it, saves pc and privilege.
// RL22 - trap return restores privilege, enable and pc.
// RL23 - interrupt taken only with global and individual enable set.
// RL24 - vectored mode still sends exceptions to the vector base.
`timescale 1ns/100ps
module hit_trap_unit (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire hit_pkg::hit_csr_req_t csr_req,
	input  wire hit_pkg::hit_irq_in_t  irq_in,
	input  wire hit_pkg::hit_exc_t     exc_in,
	input  wire logic [63:0]           cur_pc,
	input  wire logic                  machine_trap_return,
	input  wire hit_pkg::hit_pipe_t    pipe_in,
	output logic                       csr_ack,
	output logic                       csr_err,
	output logic [63:0]                csr_rdata,
	output hit_pkg::hit_fetch_t        fetch_out,
	output logic                       trap_flush,
	output logic                       pipe_stall,
	output logic [1:0]                 priv_mode
);
	typedef struct packed {
		logic        g_irq_en;
		logic        prior_irq_enable;
		logic [1:0]  prior_privilege;
		logic [1:0]  priv;
		logic [63:0] irq_enable;
		logic [63:0] return_pc;
		logic [63:0] trap_cause;
		logic [63:0] trap_vector;
		logic [3:0]  ctrl_cnt;
		logic [2:0]  ext_dly;
		logic        ext_in;
		logic        pick_valid;
		logic [5:0]  pick_code;
		logic        csr_ack;
		logic        csr_err;
		logic [63:0] csr_rdata;
		hit_pkg::hit_fetch_t fetch;
		logic        flush;
		logic        stall;
	} hit_state_t;

	hit_state_t          st_ff;
	hit_state_t          nxt_st;
	logic                rst_n_s;
	hit_pkg::hit_irq_in_t irq_s;
	logic [63:0]         pending;
	logic [63:0]         eligible;
	logic                any_elig;
	logic [5:0]          best_code;
	logic                ctrl_en;
	logic                take_exc;
	logic                take_irq;
	logic                take_ret;
	logic [3:0]          exc_code_legal;
	logic [63:0]         vec_base;

	hit_sync2 #(.W(1)) u_rst_sync (
		.ref_clk (ref_clk),
		.rst_n   (resetn),
		.d       (1'b1),
		.q       (rst_n_s)
	);

	hit_sync2 #(.W(19)) u_irq_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n_s),
		.d       (irq_in),
		.q       (irq_s)
	);

	// external line runs through the slower controller stages
	assign pending = {32'h0, irq_s.local_irq, 4'h0, st_ff.ext_dly[hit_pkg::CTRL_DLY_STAGES-1], 3'h0,
		irq_s.timer_irq, 3'h0, irq_s.soft_irq, 3'h0}; // RL1 RL2 RL18
	assign eligible = pending & st_ff.irq_enable & {64{st_ff.g_irq_en}}; // RL23
	assign any_elig = |eligible;

	// fixed priority: locals high to low, then external, software, timer
	always_comb begin
		best_code = hit_pkg::CODE_TIMER;
		if (eligible[hit_pkg::CODE_SOFT]) begin
			best_code = hit_pkg::CODE_SOFT;
		end
		if (eligible[hit_pkg::CODE_EXTERNAL]) begin
			best_code = hit_pkg::CODE_EXTERNAL; // RL12
		end
		for (int i = 0; i < 16; i++) begin
			if (eligible[16+i]) begin
				best_code = 6'(16 + i); // RL14 RL15 RL16
			end
		end
	end

	always_comb begin
		case (exc_in.code)
			hit_pkg::EXC_FETCH_MISALIGN, hit_pkg::EXC_FETCH_FAULT, hit_pkg::EXC_ILLEGAL,
			hit_pkg::EXC_BREAKPOINT, hit_pkg::EXC_LOAD_MISALIGN, hit_pkg::EXC_LOAD_FAULT,
			hit_pkg::EXC_STORE_MISALIGN, hit_pkg::EXC_STORE_FAULT, hit_pkg::EXC_ECALL_USER,
			hit_pkg::EXC_ECALL_MACHINE: exc_code_legal = exc_in.code; // RL7
			default: exc_code_legal = hit_pkg::EXC_ILLEGAL;
		endcase
	end

	assign ctrl_en  = (st_ff.ctrl_cnt == hit_pkg::CTRL_CLK_RATIO - 4'h1);
	assign vec_base = {st_ff.trap_vector[63:2], 2'b00}; // RL9
	// exception beats a picked interrupt; the level stays and is picked again
	assign take_exc = exc_in.valid;
	assign take_irq = st_ff.pick_valid && eligible[st_ff.pick_code] && !take_exc; // RL23
	assign take_ret = machine_trap_return && !take_exc && !take_irq;

	always_comb begin
		nxt_st           = st_ff;
		nxt_st.csr_ack   = 1'b0;
		nxt_st.csr_err   = 1'b0;
		nxt_st.csr_rdata = 64'h0;
		nxt_st.flush     = 1'b0;
		nxt_st.fetch     = '0;
		nxt_st.ctrl_cnt  = ctrl_en ? 4'h0 : 4'(st_ff.ctrl_cnt + 4'h1);
		// retime first, so the slow stages never add less than three full controller periods
		nxt_st.ext_in = irq_s.ext_irq; // RL18
		if (ctrl_en) begin
			nxt_st.ext_dly = {st_ff.ext_dly[1:0], st_ff.ext_in}; // RL18
		end
		// two synchroniser stages, registered pick and commit stage fill the four-cycle path
		nxt_st.pick_valid = any_elig && !take_irq; // RL17
		nxt_st.pick_code  = best_code;
		// division hazard is the only pipeline hold; traps never kill the divider
		nxt_st.stall = pipe_in.div_busy && pipe_in.issue_valid && (pipe_in.div_rd != 5'h0) &&
			((pipe_in.issue_rs1 == pipe_in.div_rd) || (pipe_in.issue_rs2 == pipe_in.div_rd)); // RL19 RL20

		if (csr_req.valid) begin
			nxt_st.csr_ack = 1'b1;
			case (csr_req.addr)
				hit_pkg::CSR_STATUS: begin
					nxt_st.csr_rdata[hit_pkg::STATUS_IRQ_ENABLE_BIT] = st_ff.g_irq_en;
					nxt_st.csr_rdata[hit_pkg::STATUS_PRIOR_IE_BIT]   = st_ff.prior_irq_enable;
					nxt_st.csr_rdata[hit_pkg::STATUS_PRIOR_PRIV_HI:hit_pkg::STATUS_PRIOR_PRIV_LO] =
						st_ff.prior_privilege;
					if (csr_req.we) begin
						nxt_st.g_irq_en         = csr_req.wdata[hit_pkg::STATUS_IRQ_ENABLE_BIT];
						nxt_st.prior_irq_enable = csr_req.wdata[hit_pkg::STATUS_PRIOR_IE_BIT];
						if (csr_req.wdata[hit_pkg::STATUS_PRIOR_PRIV_HI:hit_pkg::STATUS_PRIOR_PRIV_LO]
							== hit_pkg::PRIV_USER || csr_req.wdata[hit_pkg::STATUS_PRIOR_PRIV_HI:
							hit_pkg::STATUS_PRIOR_PRIV_LO] == hit_pkg::PRIV_MACHINE) begin
							nxt_st.prior_privilege =
								csr_req.wdata[hit_pkg::STATUS_PRIOR_PRIV_HI:hit_pkg::STATUS_PRIOR_PRIV_LO];
						end
					end
				end
				hit_pkg::CSR_IRQ_ENABLE: begin
					nxt_st.csr_rdata = st_ff.irq_enable;
					if (csr_req.we) begin
						nxt_st.irq_enable = csr_req.wdata & hit_pkg::IRQ_IMPL_MASK;
					end
				end
				hit_pkg::CSR_IRQ_PENDING: begin
					nxt_st.csr_rdata = pending; // RL1 RL2
				end
				hit_pkg::CSR_TRAP_CAUSE: begin
					nxt_st.csr_rdata = st_ff.trap_cause;
					if (csr_req.we) begin
						nxt_st.trap_cause = csr_req.wdata; // RL6
					end
				end
				hit_pkg::CSR_TRAP_VECTOR: begin
					nxt_st.csr_rdata = st_ff.trap_vector;
					if (csr_req.we) begin
						nxt_st.trap_vector[63:2] = csr_req.wdata[63:2]; // RL9
						// reserved mode values keep the old mode
						if (csr_req.wdata[1:0] == hit_pkg::MODE_DIRECT ||
							csr_req.wdata[1:0] == hit_pkg::MODE_VECTORED) begin
							nxt_st.trap_vector[1:0] = csr_req.wdata[1:0]; // RL8
						end
					end
				end
				hit_pkg::CSR_RETURN_PC: begin
					nxt_st.csr_rdata = st_ff.return_pc;
					if (csr_req.we) begin
						nxt_st.return_pc = csr_req.wdata;
					end
				end
				default: begin
					nxt_st.csr_err = 1'b1;
				end
			endcase
		end

		// trap side effects override a register write in the same cycle
		if (take_exc || take_irq) begin
			nxt_st.prior_irq_enable = st_ff.g_irq_en; // RL21
			nxt_st.g_irq_en         = 1'b0;
			nxt_st.prior_privilege  = st_ff.priv;
			nxt_st.priv             = hit_pkg::PRIV_MACHINE;
			nxt_st.return_pc        = take_exc ? exc_in.pc : cur_pc;
			nxt_st.flush            = 1'b1;
			nxt_st.fetch.valid      = 1'b1;
			nxt_st.pick_valid       = 1'b0;
			if (take_exc) begin
				nxt_st.trap_cause = {1'b0, 59'h0, exc_code_legal}; // RL5 RL6
				nxt_st.fetch.addr = vec_base; // RL10 RL24
			end else begin
				nxt_st.trap_cause = {1'b1, 57'h0, st_ff.pick_code}; // RL3 RL4 RL6
				if (st_ff.trap_vector[1:0] == hit_pkg::MODE_VECTORED) begin
					nxt_st.fetch.addr = vec_base + {56'h0, st_ff.pick_code, 2'b00}; // RL11 RL12
				end else begin
					nxt_st.fetch.addr = vec_base; // RL10
				end
			end
		end else if (take_ret) begin
			nxt_st.priv        = st_ff.prior_privilege; // RL22
			nxt_st.g_irq_en    = st_ff.prior_irq_enable;
			nxt_st.prior_irq_enable = 1'b1;
			nxt_st.prior_privilege  = hit_pkg::PRIV_USER;
			nxt_st.fetch.valid = 1'b1;
			nxt_st.fetch.addr  = st_ff.return_pc;
			nxt_st.flush       = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st_ff                  <= '0;
			st_ff.prior_privilege  <= hit_pkg::PRIV_MACHINE;
			st_ff.priv             <= hit_pkg::PRIV_MACHINE;
			st_ff.irq_enable       <= hit_pkg::IRQ_ENABLE_RST;
			st_ff.return_pc        <= hit_pkg::RETURN_PC_RST;
			st_ff.trap_cause       <= hit_pkg::TRAP_CAUSE_RST;
			st_ff.trap_vector      <= hit_pkg::TRAP_VECTOR_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign csr_ack    = st_ff.csr_ack;
	assign csr_err    = st_ff.csr_err;
	assign csr_rdata  = st_ff.csr_rdata;
	assign fetch_out  = st_ff.fetch;
	assign trap_flush = st_ff.flush;
	assign pipe_stall = st_ff.stall;
	assign priv_mode  = st_ff.priv;

	property p_pending_reserved;
		@(posedge ref_clk) disable iff (!rst_n_s)
		csr_req.valid && csr_req.addr == hit_pkg::CSR_IRQ_PENDING
			|=> csr_rdata[63:32] == 32'h0 && csr_rdata[15:12] == 4'h0 && csr_rdata[2:0] == 3'h0;
	endproperty
	a_pending_reserved: assert property (p_pending_reserved) else $error("pending reserved bits set"); // RL1 RL2

	property p_irq_cause;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_irq |=> trap_flush && st_ff.trap_cause == {1'b1, 57'h0, $past(st_ff.pick_code)};
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("interrupt cause wrong"); // RL3 RL6

	property p_timer_cause;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_irq && st_ff.pick_code == hit_pkg::CODE_TIMER |=> st_ff.trap_cause == 64'h8000_0000_0000_0007;
	endproperty
	a_timer_cause: assert property (p_timer_cause) else $error("timer cause wrong"); // RL4

	property p_exc_entry;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_exc |=> !st_ff.trap_cause[63] && fetch_out.valid && fetch_out.addr == $past(vec_base);
	endproperty
	a_exc_entry: assert property (p_exc_entry) else $error("exception entry wrong"); // RL5 RL24

	property p_vectored_irq;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_irq && st_ff.trap_vector[1:0] == hit_pkg::MODE_VECTORED
			|=> fetch_out.addr == $past(vec_base) + {56'h0, $past(st_ff.pick_code), 2'b00};
	endproperty
	a_vectored_irq: assert property (p_vectored_irq) else $error("vectored address wrong"); // RL11

	property p_direct_irq;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_irq && st_ff.trap_vector[1:0] == hit_pkg::MODE_DIRECT |=> fetch_out.addr == $past(vec_base);
	endproperty
	a_direct_irq: assert property (p_direct_irq) else $error("direct address wrong"); // RL10

	property p_local15_wins;
		@(posedge ref_clk) disable iff (!rst_n_s)
		eligible[31] && !take_irq && !take_exc |=> st_ff.pick_code == 6'h1F;
	endproperty
	a_local15_wins: assert property (p_local15_wins) else $error("local 15 not picked"); // RL15 RL16

	property p_entry_enable;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_exc || take_irq |=> !st_ff.g_irq_en && st_ff.prior_irq_enable == $past(st_ff.g_irq_en)
			&& st_ff.return_pc == ($past(take_exc) ? $past(exc_in.pc) : $past(cur_pc));
	endproperty
	a_entry_enable: assert property (p_entry_enable) else $error("trap entry state wrong"); // RL21

	property p_return;
		@(posedge ref_clk) disable iff (!rst_n_s)
		take_ret |=> st_ff.g_irq_en == $past(st_ff.prior_irq_enable) && fetch_out.addr == $past(st_ff.return_pc)
			&& priv_mode == $past(st_ff.prior_privilege);
	endproperty
	a_return: assert property (p_return) else $error("trap return wrong"); // RL22

	property p_div_stall;
		@(posedge ref_clk) disable iff (!rst_n_s)
		pipe_in.div_busy && pipe_in.issue_valid && pipe_in.div_rd != 5'h0 && pipe_in.issue_rs1 == pipe_in.div_rd
			|=> pipe_stall;
	endproperty
	a_div_stall: assert property (p_div_stall) else $error("division hazard not stalled"); // RL20
endmodule

// ===== design/hit_pkg.sv
// shared constants and carrier types of the hart interrupt and trap unit
package hit_pkg;

	localparam int unsigned XLEN        = 64;
	localparam int unsigned CSR_ADDR_W  = 12;
	localparam int unsigned LOCAL_NUM   = 16;

	// control register addresses on the core's register port
	localparam logic [11:0] CSR_STATUS      = 12'h300;
	localparam logic [11:0] CSR_IRQ_ENABLE  = 12'h304;
	localparam logic [11:0] CSR_TRAP_VECTOR = 12'h305;
	localparam logic [11:0] CSR_RETURN_PC   = 12'h341;
	localparam logic [11:0] CSR_TRAP_CAUSE  = 12'h342;
	localparam logic [11:0] CSR_IRQ_PENDING = 12'h344;

	// status fields
	localparam int unsigned STATUS_IRQ_ENABLE_BIT = 3;
	localparam int unsigned STATUS_PRIOR_IE_BIT   = 7;
	localparam int unsigned STATUS_PRIOR_PRIV_LO  = 11;
	localparam int unsigned STATUS_PRIOR_PRIV_HI  = 12;

	// pending and enable bit positions, equal to the interrupt codes
	localparam logic [5:0] CODE_SOFT     = 6'h03;
	localparam logic [5:0] CODE_TIMER    = 6'h07;
	localparam logic [5:0] CODE_EXTERNAL = 6'h0B;
	localparam logic [5:0] CODE_LOCAL0   = 6'h10;
	localparam logic [63:0] IRQ_IMPL_MASK = 64'h0000_0000_FFFF_0888;

	// synchronous exception codes
	localparam logic [3:0] EXC_FETCH_MISALIGN = 4'h0;
	localparam logic [3:0] EXC_FETCH_FAULT    = 4'h1;
	localparam logic [3:0] EXC_ILLEGAL        = 4'h2;
	localparam logic [3:0] EXC_BREAKPOINT     = 4'h3;
	localparam logic [3:0] EXC_LOAD_MISALIGN  = 4'h4;
	localparam logic [3:0] EXC_LOAD_FAULT     = 4'h5;
	localparam logic [3:0] EXC_STORE_MISALIGN = 4'h6;
	localparam logic [3:0] EXC_STORE_FAULT    = 4'h7;
	localparam logic [3:0] EXC_ECALL_USER     = 4'h8;
	localparam logic [3:0] EXC_ECALL_MACHINE  = 4'hB;

	// vector mode and privilege encodings
	localparam logic [1:0] MODE_DIRECT   = 2'h0;
	localparam logic [1:0] MODE_VECTORED = 2'h1;
	localparam logic [1:0] PRIV_USER     = 2'h0;
	localparam logic [1:0] PRIV_MACHINE  = 2'h3;

	// reset values
	localparam logic [63:0] TRAP_VECTOR_RST = 64'h0000_0000_0000_0000;
	localparam logic [63:0] TRAP_CAUSE_RST  = 64'h0000_0000_0000_0000;
	localparam logic [63:0] RETURN_PC_RST   = 64'h0000_0000_0000_0000;
	localparam logic [63:0] IRQ_ENABLE_RST  = 64'h0000_0000_0000_0000;

	// global controller clock: core cycles per controller cycle, and its extra stages
	localparam logic [3:0] CTRL_CLK_RATIO  = 4'h2;
	localparam int unsigned CTRL_DLY_STAGES = 3;

	typedef struct packed {
		logic                  valid;
		logic                  we;
		logic [CSR_ADDR_W-1:0] addr;
		logic [XLEN-1:0]       wdata;
	} hit_csr_req_t;

	typedef struct packed {
		logic [LOCAL_NUM-1:0] local_irq;
		logic                 ext_irq;
		logic                 timer_irq;
		logic                 soft_irq;
	} hit_irq_in_t;

	typedef struct packed {
		logic            valid;
		logic [3:0]      code;
		logic [XLEN-1:0] pc;
	} hit_exc_t;

	typedef struct packed {
		logic       div_busy;
		logic [4:0] div_rd;
		logic       issue_valid;
		logic [4:0] issue_rs1;
		logic [4:0] issue_rs2;
	} hit_pipe_t;

	typedef struct packed {
		logic            valid;
		logic [XLEN-1:0] addr;
	} hit_fetch_t;

endpackage

// ===== design/hit_sync2.sv
// two flip-flop synchroniser for levels entering the core clock domain
`timescale 1ns/100ps
module hit_sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hit_sync_st_t;

	hit_sync_st_t st_ff;
	hit_sync_st_t nxt_st;

	// first stage feeds only the second
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = d;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q = st_ff.s2;
endmodule

// ===== verification/hit_irq_src.sv
// interrupt source model: level lines held until the handler services them
`timescale 1ns/100ps
module hit_irq_src (
	input  wire logic            ref_clk,
	input  wire logic            resetn,
	input  wire logic [18:0]     raise,
	input  wire logic [18:0]     lower,
	output hit_pkg::hit_irq_in_t irq_out
);
	logic [18:0] level_ff;

	// level sources keep asserting until serviced, like a controller line
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			level_ff <= 19'h00000;
		end else begin
			level_ff <= (level_ff | raise) & ~lower;
		end
	end

	assign irq_out = level_ff;
endmodule

// ===== verification/test_hart_interrupt_trap_unit.sv
// register, interrupt, exception, return and stall tests of the trap unit
`timescale 1ns/100ps
module test_hart_interrupt_trap_unit;
	logic                  ref_clk;
	logic                  resetn;
	hit_pkg::hit_csr_req_t csr_req;
	hit_pkg::hit_irq_in_t  irq_in;
	hit_pkg::hit_exc_t     exc_in;
	logic [63:0]           cur_pc;
	logic                  machine_trap_return;
	hit_pkg::hit_pipe_t    pipe_in;
	logic                  csr_ack;
	logic                  csr_err;
	logic [63:0]           csr_rdata;
	hit_pkg::hit_fetch_t   fetch_out;
	logic                  trap_flush;
	logic                  pipe_stall;
	logic [1:0]            priv_mode;
	logic [18:0]           raise;
	logic [18:0]           lower;
	int                    failures;
	int                    cmp_count;

	localparam logic [63:0] BASE = 64'h0000_0000_0000_1000;
	localparam logic [63:0] RET_PC = 64'h0000_0000_0000_4444;
	localparam logic [63:0] IRQ = 64'h8000_0000_0000_0000;

	hit_trap_unit u_dut (.ref_clk(ref_clk), .resetn(resetn), .csr_req(csr_req), .irq_in(irq_in),
		.exc_in(exc_in), .cur_pc(cur_pc), .machine_trap_return(machine_trap_return), .pipe_in(pipe_in),
		.csr_ack(csr_ack), .csr_err(csr_err), .csr_rdata(csr_rdata), .fetch_out(fetch_out),
		.trap_flush(trap_flush), .pipe_stall(pipe_stall), .priv_mode(priv_mode));

	hit_irq_src u_src (.ref_clk(ref_clk), .resetn(resetn), .raise(raise), .lower(lower), .irq_out(irq_in));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// one access: request held for exactly the taking edge, answer one cycle later
	task automatic acc(input logic we, input logic [11:0] addr, input logic [63:0] wd, input logic [63:0] exp,
		input logic err);
		@(posedge ref_clk);
		csr_req <= '{1'b1, we, addr, wd};
		@(posedge ref_clk);
		csr_req <= '{1'b0, 1'b0, 12'h000, 64'h0};
		#1;
		chk({63'h0, csr_ack}, 64'h1);
		chk({63'h0, csr_err}, {63'h0, err});
		if (!we) chk(csr_rdata, exp);
	endtask

	task automatic rd(input logic [11:0] addr, input logic [63:0] exp);
		acc(1'b0, addr, 64'h0, exp, 1'b0);
	endtask

	task automatic wr(input logic [11:0] addr, input logic [63:0] wd);
		acc(1'b1, addr, wd, 64'h0, 1'b0);
	endtask

	task automatic src(input logic [18:0] bits, input logic up);
		@(posedge ref_clk);
		if (up) raise <= bits;
		else lower <= bits;
		@(posedge ref_clk);
		raise <= 19'h0;
		lower <= 19'h0;
	endtask

	task automatic check_fetch(input logic [63:0] exp_addr);
		chk({63'h0, fetch_out.valid}, 64'h1);
		chk(fetch_out.addr, exp_addr);
		chk({63'h0, trap_flush}, 64'h1);
	endtask

	// counts edges until the redirect; running out of the bound ends the run
	task automatic wait_fetch(input logic [63:0] exp_addr, input int bound, output int n);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (fetch_out.valid !== 1'b1 && n < bound);
		check_fetch(exp_addr);
		if (fetch_out.valid !== 1'b1) summarize();
	endtask

	task automatic quiet(input int cycles);
		repeat (cycles) begin
			@(posedge ref_clk);
			#1;
			chk({63'h0, fetch_out.valid}, 64'h0);
		end
	endtask

	task automatic exc(input logic [3:0] code, input logic [63:0] pc);
		@(posedge ref_clk);
		exc_in <= '{1'b1, code, pc};
		@(posedge ref_clk);
		exc_in <= '{1'b0, 4'h0, 64'h0};
		#1;
	endtask

	task automatic ret();
		@(posedge ref_clk);
		machine_trap_return <= 1'b1;
		@(posedge ref_clk);
		machine_trap_return <= 1'b0;
		#1;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	initial begin
		int n;
		int k;
		static int codes[6] = '{31, 22, 16, 11, 3, 7};
		static int bits[6] = '{18, 9, 3, 2, 0, 1};
		resetn = 1'b0;
		csr_req = '0;
		exc_in = '0;
		cur_pc = RET_PC;
		machine_trap_return = 1'b0;
		pipe_in = '0;
		raise = 19'h0;
		lower = 19'h0;
		failures = 0;
		cmp_count = 0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(hit_pkg::CSR_TRAP_VECTOR, 64'h0);
		rd(hit_pkg::CSR_TRAP_CAUSE, 64'h0);
		rd(hit_pkg::CSR_STATUS, 64'h1800);
		acc(1'b0, 12'h7C0, 64'h0, 64'h0, 1'b1);
		wr(hit_pkg::CSR_IRQ_PENDING, '1);
		rd(hit_pkg::CSR_IRQ_PENDING, 64'h0);
		wr(hit_pkg::CSR_IRQ_ENABLE, '1);
		rd(hit_pkg::CSR_IRQ_ENABLE, 64'hFFFF_0888);
		wr(hit_pkg::CSR_IRQ_ENABLE, 64'h0);
		wr(hit_pkg::CSR_TRAP_VECTOR, BASE | 64'h2);
		rd(hit_pkg::CSR_TRAP_VECTOR, BASE);
		wr(hit_pkg::CSR_TRAP_VECTOR, BASE | 64'h1);
		rd(hit_pkg::CSR_TRAP_VECTOR, BASE | 64'h1);
		src(19'h4020F, 1'b1);
		repeat (12) @(posedge ref_clk);
		rd(hit_pkg::CSR_IRQ_PENDING, 64'h8041_0888);
		wr(hit_pkg::CSR_IRQ_ENABLE, '1);
		// all six pending at once: each re-enable takes the next in priority order
		for (k = 0; k < 6; k++) begin
			wr(hit_pkg::CSR_STATUS, 64'h8);
			wait_fetch(BASE + 64'(4 * codes[k]), 16, n);
			rd(hit_pkg::CSR_TRAP_CAUSE, IRQ | 64'(codes[k]));
			src(19'h1 << bits[k], 1'b0);
			repeat (6) @(posedge ref_clk);
		end
		rd(hit_pkg::CSR_STATUS, 64'h1880);
		rd(hit_pkg::CSR_RETURN_PC, RET_PC);
		wr(hit_pkg::CSR_STATUS, 64'h8);
		src(19'h2, 1'b1);
		wait_fetch(BASE + 64'h1C, 16, n);
		chk(64'(n), 64'h4);
		src(19'h2, 1'b0);
		repeat (6) @(posedge ref_clk);
		wr(hit_pkg::CSR_STATUS, 64'h8);
		src(19'h4, 1'b1);
		wait_fetch(BASE + 64'h2C, 20, n);
		chk({63'h0, n inside {10, 11}}, 64'h1);
		src(19'h4, 1'b0);
		repeat (6) @(posedge ref_clk);
		wr(hit_pkg::CSR_IRQ_ENABLE, 64'h0);
		wr(hit_pkg::CSR_STATUS, 64'h8);
		src(19'h1, 1'b1);
		quiet(12);
		wr(hit_pkg::CSR_IRQ_ENABLE, 64'h8);
		wait_fetch(BASE + 64'hC, 16, n);
		quiet(12);
		src(19'h1, 1'b0);
		repeat (6) @(posedge ref_clk);
		for (k = 0; k < 12; k++) begin
			exc(4'(k), 64'h200 + 64'(k));
			check_fetch(BASE);
			rd(hit_pkg::CSR_TRAP_CAUSE, (k == 9 || k == 10) ? 64'h2 : 64'(k));
		end
		rd(hit_pkg::CSR_RETURN_PC, 64'h20B);
		wr(hit_pkg::CSR_TRAP_VECTOR, 64'h3000);
		wr(hit_pkg::CSR_IRQ_ENABLE, 64'h88);
		wr(hit_pkg::CSR_STATUS, 64'h8);
		src(19'h2, 1'b1);
		wait_fetch(64'h3000, 16, n);
		rd(hit_pkg::CSR_TRAP_CAUSE, IRQ | 64'h7);
		src(19'h2, 1'b0);
		repeat (6) @(posedge ref_clk);
		ret();
		check_fetch(RET_PC);
		chk({62'h0, priv_mode}, 64'h3);
		rd(hit_pkg::CSR_STATUS, 64'h0088);
		ret();
		check_fetch(RET_PC);
		chk({62'h0, priv_mode}, 64'h0);
		exc(hit_pkg::EXC_ECALL_USER, 64'h300);
		check_fetch(64'h3000);
		chk({62'h0, priv_mode}, 64'h3);
		rd(hit_pkg::CSR_STATUS, 64'h0080);
		@(posedge ref_clk);
		pipe_in <= '{1'b1, 5'h05, 1'b1, 5'h05, 5'h00};
		@(posedge ref_clk);
		#1;
		chk({63'h0, pipe_stall}, 64'h1);
		// a trap during the divide must leave the hazard standing
		exc(hit_pkg::EXC_ILLEGAL, 64'h400);
		check_fetch(64'h3000);
		chk({63'h0, pipe_stall}, 64'h1);
		@(posedge ref_clk);
		pipe_in <= '0;
		@(posedge ref_clk);
		#1;
		chk({63'h0, pipe_stall}, 64'h0);
		summarize();
	end
endmodule
